// ### pkg/ess_params.svh
// Purpose: constants of the engine start sequencer
// Assumes: 10 MHz system clock, APB register access
// Notes: offsets are byte addresses on the APB
`ifndef ESS_PARAMS_SVH
`define ESS_PARAMS_SVH

// Timing
`define ESS_CLK_PERIOD_NS 100
`define ESS_SECOND_NS 1000000000
`define ESS_TICK_CYCLES (`ESS_SECOND_NS / `ESS_CLK_PERIOD_NS)
`define ESS_TICK_CNT_MAX 24'hffffff
`define ESS_POWERUP_HOLD_S 16'h0001
`define ESS_SEC_MAX 6'h3b
`define ESS_MIN_MAX 6'h3b
`define ESS_HOUR_MAX 5'h17
`define ESS_WDAY_MAX 3'h6
`define ESS_MONTH_MAX 4'hc

// Register offsets
`define ESS_CTRL_OFS 8'h00
`define ESS_START_DLY_OFS 8'h04
`define ESS_PRESTART_DLY_OFS 8'h08
`define ESS_ECU_WAIT_OFS 8'h0c
`define ESS_CRANK_TIME_OFS 8'h10
`define ESS_STATUS_OFS 8'h14
`define ESS_TIME_OFS 8'h18
`define ESS_DATE_OFS 8'h1c

// Field positions
`define ESS_CTRL_ECU_BIT 0
`define ESS_STAT_STATE_LSB 0
`define ESS_STAT_SEL_LSB 4
`define ESS_STAT_SHUT_BIT 8
`define ESS_STAT_KEY_LSB 12
`define ESS_TIME_SEC_LSB 0
`define ESS_TIME_MIN_LSB 8
`define ESS_TIME_HOUR_LSB 16
`define ESS_TIME_WDAY_LSB 24
`define ESS_DATE_DAY_LSB 0
`define ESS_DATE_MON_LSB 8
`define ESS_DATE_YEAR_LSB 16

// Reset values
`define ESS_START_DLY_RST 16'h000a
`define ESS_PRESTART_DLY_RST 16'h0005
`define ESS_ECU_WAIT_RST 16'h000a
`define ESS_CRANK_TIME_RST 16'h000f
`define ESS_YEAR_RST 16'h07d0
`define ESS_DAY_RST 5'h01
`define ESS_MONTH_RST 4'h1

`endif

// ### pkg/ess_pkg.sv
// Purpose: types of the engine start sequencer
// Assumes: nothing beyond SystemVerilog packages
// Notes: constants live in ess_params.svh
package ess_pkg;

    typedef enum logic [1:0] {
        ESS_KEY_OFF,
        ESS_KEY_AUTO,
        ESS_KEY_MANUAL_POSITION
    } ess_key_type;

    typedef enum logic [2:0] {
        ESS_ST_NOT_READY,
        ESS_ST_PANEL_READY,
        ESS_ST_START_DELAY,
        ESS_ST_PRESTART,
        ESS_ST_ELECTRONICS_WARMUP,
        ESS_ST_CRANK_ON,
        ESS_ST_HANDOFF
    } ess_state_type;

    typedef enum logic [3:0] {
        ESS_SEL_OFF,
        ESS_SEL_AUTO,
        ESS_SEL_MANUAL,
        ESS_SEL_START_DELAY,
        ESS_SEL_STOP_DELAY,
        ESS_SEL_PRESSURE,
        ESS_SEL_LEVEL,
        ESS_SEL_FLOAT,
        ESS_SEL_REMOTE,
        ESS_SEL_CLOCK
    } ess_sel_type;

    typedef struct packed {
        logic pressure;
        logic level;
        logic float_sw;
        logic remote_supervisory_start;
        logic clock_sched;
    } ess_start_req_type;

    typedef struct packed {
        logic [15:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [2:0] weekday;
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
    } ess_datetime_type;

    typedef struct packed {
        logic ecu_engine;
        logic [15:0] start_dly;
        logic [15:0] prestart_dly;
        logic [15:0] ecu_wait;
        logic [15:0] crank_time;
    } ess_config_type;

    typedef struct packed {
        logic [23:0] cnt;
        logic tick;
    } ess_tick_state_type;

    typedef struct packed {
        ess_state_type state;
        logic [15:0] sec_cnt;
        logic pwr_done;
        logic shut;
        logic prestart;
        logic crank;
        ess_sel_type sel;
        ess_config_type cfg;
        ess_datetime_type dt;
        logic [31:0] prdata;
        logic pslverr;
    } ess_seq_state_type;

endpackage

// ### design/ess_sec_tick.sv
// Purpose: one-second tick from the system clock
// Assumes: TICK_CYCLES clock cycles per second
// Notes: tick_o is a one-cycle pulse from a flop
`timescale 1ns/1ns
`default_nettype none
`include "ess_params.svh"

module ess_sec_tick
    import ess_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `ESS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Tick
    output logic tick_o
);

    localparam logic [23:0] LAST = 24'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 2 || TICK_CYCLES > 24'hffffff) begin : g_bad
        $error("TICK_CYCLES out of range");
    end

    ess_tick_state_type s_q;
    ess_tick_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 24'h000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;

    a_tick_period: assert property (@(posedge clk_i) disable iff (reset_i)
        s_q.tick |-> s_q.cnt == 24'h000000 && $past(s_q.cnt) == LAST)
        else $error("tick not at counter wrap");

endmodule
`default_nettype wire

// ### design/ess_sequencer.sv
// Purpose: automatic start front end of an engine controller
// Assumes: synchronous inputs, APB slave with no wait states
// Notes: later engine states are handled downstream of handoff
`timescale 1ns/1ns
`default_nettype none
`include "ess_params.svh"

module ess_sequencer
    import ess_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `ESS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Panel and engine inputs
    input wire ess_key_type key_i,
    input wire logic shutdown_i,
    input wire ess_start_req_type start_req_i,
    input wire logic engine_running_i,
    // Drives
    output logic prestart_o,
    output logic crank_o,
    output logic handoff_o,
    // Display
    output logic [2:0] state_code_o,
    output ess_sel_type key_position_field_o,
    output ess_datetime_type datetime_o
);

    ess_seq_state_type s_q;
    ess_seq_state_type s_d;
    logic tick;
    logic start_any;
    logic setup;
    logic access;

    // Leap year test
    function automatic logic is_leap(input logic [15:0] y);
        is_leap = (y % 16'h0004 == 16'h0000) &&
                  ((y % 16'h0064 != 16'h0000) ||
                   (y % 16'h0190 == 16'h0000));
    endfunction

    // Days in a month
    function automatic logic [4:0] month_days(input logic [3:0] m,
                                              input logic [15:0] y);
        case (m)
            4'h2: month_days = is_leap(y) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
            default: month_days = 5'h1f;
        endcase
    endfunction

    // One second forward on the calendar
    function automatic ess_datetime_type dt_advance(
        input ess_datetime_type t
    );
        ess_datetime_type r;
        r = t;
        if (t.seconds < `ESS_SEC_MAX) begin
            r.seconds = t.seconds + 6'h01;
        end else begin
            r.seconds = '0;
            if (t.minutes < `ESS_MIN_MAX) begin
                r.minutes = t.minutes + 6'h01;
            end else begin
                r.minutes = '0;
                if (t.hours < `ESS_HOUR_MAX) begin
                    r.hours = t.hours + 5'h01;
                end else begin
                    r.hours = '0;
                    r.weekday = (t.weekday < `ESS_WDAY_MAX) ?
                                t.weekday + 3'h1 : 3'h0;
                    if (t.day < month_days(t.month, t.year)) begin
                        r.day = t.day + 5'h01;
                    end else begin
                        r.day = 5'h01;
                        if (t.month < `ESS_MONTH_MAX) begin
                            r.month = t.month + 4'h1;
                        end else begin
                            r.month = 4'h1;
                            r.year = t.year + 16'h0001;
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    ess_sec_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_o(tick)
    );

    assign start_any = |start_req_i;
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;

    always_comb begin
        s_d = s_q;

        if (tick && s_q.sec_cnt != 16'hffff) begin
            s_d.sec_cnt = s_q.sec_cnt + 16'h0001;
        end

        if (tick) begin
            s_d.dt = dt_advance(s_q.dt);
        end

        // Shutdown latch, a new event beats the key clear
        if (key_i == ESS_KEY_OFF) begin
            s_d.shut = 1'b0;
        end
        if (shutdown_i) begin
            s_d.shut = 1'b1;
        end

        case (s_q.state)
            ESS_ST_NOT_READY: begin
                if (!s_q.pwr_done) begin
                    if (s_q.sec_cnt >= `ESS_POWERUP_HOLD_S) begin
                        s_d.pwr_done = 1'b1;
                    end
                end else if (key_i != ESS_KEY_OFF && !s_q.shut) begin
                    s_d.state = ESS_ST_PANEL_READY;
                end
            end
            ESS_ST_PANEL_READY: begin
                if (key_i == ESS_KEY_AUTO && start_any) begin
                    s_d.state = ESS_ST_START_DELAY;
                end
            end
            ESS_ST_START_DELAY: begin
                if (!start_any || key_i != ESS_KEY_AUTO) begin
                    s_d.state = ESS_ST_PANEL_READY;
                end else if (s_q.sec_cnt >= s_q.cfg.start_dly) begin
                    s_d.state = ESS_ST_PRESTART;
                end
            end
            ESS_ST_PRESTART: begin
                if (s_q.sec_cnt >= s_q.cfg.prestart_dly) begin
                    s_d.state = s_q.cfg.ecu_engine ?
                                ESS_ST_ELECTRONICS_WARMUP :
                                ESS_ST_CRANK_ON;
                end
            end
            ESS_ST_ELECTRONICS_WARMUP: begin
                if (s_q.sec_cnt >= s_q.cfg.ecu_wait) begin
                    s_d.state = ESS_ST_CRANK_ON;
                end
            end
            ESS_ST_CRANK_ON: begin
                if (engine_running_i ||
                    s_q.sec_cnt >= s_q.cfg.crank_time) begin
                    s_d.state = ESS_ST_HANDOFF;
                end
            end
            ESS_ST_HANDOFF: begin
                s_d.state = ESS_ST_HANDOFF;
            end
            default: begin
                s_d.state = ESS_ST_NOT_READY;
            end
        endcase

        // key off or shutdown forces not-ready
        if (key_i == ESS_KEY_OFF || s_q.shut || shutdown_i) begin
            s_d.state = ESS_ST_NOT_READY;
        end

        if (s_d.state != s_q.state) begin
            s_d.sec_cnt = '0;
        end

        s_d.prestart = (s_d.state == ESS_ST_PRESTART);
        s_d.crank = (s_d.state == ESS_ST_CRANK_ON);

        if (start_any && key_i != ESS_KEY_OFF) begin
            if (s_q.state == ESS_ST_START_DELAY) begin
                s_d.sel = ESS_SEL_START_DELAY;
            end else if (start_req_i.pressure) begin
                s_d.sel = ESS_SEL_PRESSURE;
            end else if (start_req_i.level) begin
                s_d.sel = ESS_SEL_LEVEL;
            end else if (start_req_i.float_sw) begin
                s_d.sel = ESS_SEL_FLOAT;
            end else if (start_req_i.remote_supervisory_start) begin
                s_d.sel = ESS_SEL_REMOTE;
            end else begin
                s_d.sel = ESS_SEL_CLOCK;
            end
        end else begin
            case (key_i)
                ESS_KEY_AUTO: s_d.sel = ESS_SEL_AUTO;
                ESS_KEY_MANUAL_POSITION: s_d.sel = ESS_SEL_MANUAL;
                default: s_d.sel = ESS_SEL_OFF;
            endcase
        end

        // Read data and decode error prepared in setup
        if (setup) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            case (paddr_i)
                `ESS_CTRL_OFS:
                    s_d.prdata[`ESS_CTRL_ECU_BIT] = s_q.cfg.ecu_engine;
                `ESS_START_DLY_OFS:
                    s_d.prdata[15:0] = s_q.cfg.start_dly;
                `ESS_PRESTART_DLY_OFS:
                    s_d.prdata[15:0] = s_q.cfg.prestart_dly;
                `ESS_ECU_WAIT_OFS:
                    s_d.prdata[15:0] = s_q.cfg.ecu_wait;
                `ESS_CRANK_TIME_OFS:
                    s_d.prdata[15:0] = s_q.cfg.crank_time;
                `ESS_STATUS_OFS: begin
                    s_d.prdata[`ESS_STAT_STATE_LSB +: 3] = s_q.state;
                    s_d.prdata[`ESS_STAT_SEL_LSB +: 4] = s_q.sel;
                    s_d.prdata[`ESS_STAT_SHUT_BIT] = s_q.shut;
                    s_d.prdata[`ESS_STAT_KEY_LSB +: 2] = key_i;
                end
                `ESS_TIME_OFS: begin
                    s_d.prdata[`ESS_TIME_SEC_LSB +: 6] = s_q.dt.seconds;
                    s_d.prdata[`ESS_TIME_MIN_LSB +: 6] = s_q.dt.minutes;
                    s_d.prdata[`ESS_TIME_HOUR_LSB +: 5] = s_q.dt.hours;
                    s_d.prdata[`ESS_TIME_WDAY_LSB +: 3] = s_q.dt.weekday;
                end
                `ESS_DATE_OFS: begin
                    s_d.prdata[`ESS_DATE_DAY_LSB +: 5] = s_q.dt.day;
                    s_d.prdata[`ESS_DATE_MON_LSB +: 4] = s_q.dt.month;
                    s_d.prdata[`ESS_DATE_YEAR_LSB +: 16] = s_q.dt.year;
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // Writes take effect in the access cycle
        if (access && pwrite_i) begin
            case (paddr_i)
                `ESS_CTRL_OFS:
                    s_d.cfg.ecu_engine = pwdata_i[`ESS_CTRL_ECU_BIT];
                `ESS_START_DLY_OFS:
                    s_d.cfg.start_dly = pwdata_i[15:0];
                `ESS_PRESTART_DLY_OFS:
                    s_d.cfg.prestart_dly = pwdata_i[15:0];
                `ESS_ECU_WAIT_OFS:
                    s_d.cfg.ecu_wait = pwdata_i[15:0];
                `ESS_CRANK_TIME_OFS:
                    s_d.cfg.crank_time = pwdata_i[15:0];
                `ESS_TIME_OFS: begin
                    s_d.dt.seconds = pwdata_i[`ESS_TIME_SEC_LSB +: 6];
                    s_d.dt.minutes = pwdata_i[`ESS_TIME_MIN_LSB +: 6];
                    s_d.dt.hours = pwdata_i[`ESS_TIME_HOUR_LSB +: 5];
                    s_d.dt.weekday = pwdata_i[`ESS_TIME_WDAY_LSB +: 3];
                end
                `ESS_DATE_OFS: begin
                    s_d.dt.day = pwdata_i[`ESS_DATE_DAY_LSB +: 5];
                    s_d.dt.month = pwdata_i[`ESS_DATE_MON_LSB +: 4];
                    s_d.dt.year = pwdata_i[`ESS_DATE_YEAR_LSB +: 16];
                end
                default: begin
                    s_d.cfg = s_q.cfg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.state <= ESS_ST_NOT_READY;
            s_q.sel <= ESS_SEL_OFF;
            s_q.cfg.start_dly <= `ESS_START_DLY_RST;
            s_q.cfg.prestart_dly <= `ESS_PRESTART_DLY_RST;
            s_q.cfg.ecu_wait <= `ESS_ECU_WAIT_RST;
            s_q.cfg.crank_time <= `ESS_CRANK_TIME_RST;
            s_q.dt.year <= `ESS_YEAR_RST;
            s_q.dt.month <= `ESS_MONTH_RST;
            s_q.dt.day <= `ESS_DAY_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = access && s_q.pslverr;
    assign prestart_o = s_q.prestart;
    assign crank_o = s_q.crank;
    assign handoff_o = (s_q.state == ESS_ST_HANDOFF);
    assign state_code_o = s_q.state;
    assign key_position_field_o = s_q.sel;
    assign datetime_o = s_q.dt;

    a_off_holds_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (key_i == ESS_KEY_OFF)[*2] |-> s_q.state == ESS_ST_NOT_READY)
        else $error("sequence running with key off");

    a_powerup_not_ready: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !s_q.pwr_done |-> s_q.state == ESS_ST_NOT_READY)
        else $error("left not-ready during power-up hold");

    a_ready_entry: assert property (@(posedge clk_i) disable iff (reset_i)
        s_q.state == ESS_ST_NOT_READY && s_q.pwr_done &&
        key_i == ESS_KEY_AUTO && !s_q.shut && !shutdown_i
        |=> s_q.state == ESS_ST_PANEL_READY)
        else $error("panel-ready not entered");

    a_delay_entry: assert property (@(posedge clk_i) disable iff (reset_i)
        s_q.state == ESS_ST_PANEL_READY && key_i == ESS_KEY_AUTO &&
        start_any && !shutdown_i
        |=> s_q.state == ESS_ST_START_DELAY && s_q.sec_cnt == 16'h0000)
        else $error("start-delay not entered");

    a_delay_held: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(s_q.state == ESS_ST_PRESTART) |->
        $past(start_any) &&
        $past(s_q.sec_cnt) >= $past(s_q.cfg.start_dly))
        else $error("prestart without held request");

    a_prestart_drive: assert property (@(posedge clk_i)
        disable iff (reset_i)
        $rose(prestart_o) |-> $past(s_q.state) == ESS_ST_START_DELAY &&
        s_q.state == ESS_ST_PRESTART)
        else $error("prestart drive out of step");

    a_warmup_entry: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(s_q.state == ESS_ST_ELECTRONICS_WARMUP) |->
        $past(s_q.state) == ESS_ST_PRESTART && s_q.cfg.ecu_engine)
        else $error("warm-up wait without electronic engine");

    a_crank_drive: assert property (@(posedge clk_i) disable iff (reset_i)
        crank_o == (s_q.state == ESS_ST_CRANK_ON) &&
        prestart_o == (s_q.state == ESS_ST_PRESTART))
        else $error("crank drive differs from state");

    a_sel_key: assert property (@(posedge clk_i) disable iff (reset_i)
        !start_any && key_i == ESS_KEY_MANUAL_POSITION
        |=> key_position_field_o == ESS_SEL_MANUAL)
        else $error("key field not manual");

    a_sel_delay: assert property (@(posedge clk_i) disable iff (reset_i)
        start_any && key_i == ESS_KEY_AUTO &&
        s_q.state == ESS_ST_START_DELAY
        |=> key_position_field_o == ESS_SEL_START_DELAY)
        else $error("key field not start-delay");

    a_second_roll: assert property (@(posedge clk_i) disable iff (reset_i)
        tick && s_q.dt.seconds == `ESS_SEC_MAX && !access
        |=> s_q.dt.seconds == 6'h00)
        else $error("seconds did not roll over");

    a_timer_restart: assert property (@(posedge clk_i)
        disable iff (reset_i)
        $changed(s_q.state) |-> s_q.sec_cnt == 16'h0000)
        else $error("timer not restarted on entry");

    a_off_drops_drives: assert property (@(posedge clk_i)
        disable iff (reset_i)
        key_i == ESS_KEY_OFF |=> !prestart_o && !crank_o &&
        s_q.state == ESS_ST_NOT_READY)
        else $error("drives on after key off");

endmodule
`default_nettype wire

// ### verif/ess_engine_model.sv
// Purpose: engine that answers the crank drive
// Assumes: run_dly_i cranking cycles fire the engine
// Notes: run_dly_i of zero is an engine that never fires
`timescale 1ns/1ns
`default_nettype none
module ess_engine_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Engine
    input wire logic crank_i,
    input wire logic [7:0] run_dly_i,
    output logic running_o
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (reset_i || run_dly_i == 8'h00) begin
            cnt_q <= 8'h00;
            running_o <= 1'b0;
        end else if (crank_i) begin
            cnt_q <= cnt_q + 8'h01;
            running_o <= running_o | (cnt_q + 8'h01 >= run_dly_i);
        end
    end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Purpose: self-checking bench of the start sequencer
// Assumes: ten clock cycles to a second
// Notes: delays are shortened over the register bus
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ess_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, run, prestart, crank, hand;
    ess_key_type key = ESS_KEY_AUTO;
    logic shut = 1'b0;
    ess_start_req_type req = '0;
    logic [7:0] run_dly = 8'h00;
    logic [2:0] st;
    ess_sel_type fld;
    ess_datetime_type dt;
    logic saw4 = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    ess_sequencer #(.TICK_CYCLES(10)) dut (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .key_i(key),
        .shutdown_i(shut), .start_req_i(req), .engine_running_i(run),
        .prestart_o(prestart), .crank_o(crank), .handoff_o(hand),
        .state_code_o(st), .key_position_field_o(fld), .datetime_o(dt));
    ess_engine_model eng (.clk_i(clk_i), .reset_i(reset_i),
        .crank_i(crank), .run_dly_i(run_dly), .running_o(run));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (st === 3'h4) saw4 <= 1'b1;
        else if (st === 3'h2) saw4 <= 1'b0;
    end
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang;
        num_errors++;
        $display("mismatch wait expected done seen timeout");
        tally_and_finish();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            i++;
        end while (pready !== 1'b1 && i < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) hang();
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask
    task automatic wst(input logic [2:0] s, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (st !== s && n < 300);
        if (n >= 300) hang();
    endtask
    task automatic t_power;
        int n;
        cyc(2);
        chk("state", 32'h0, st);
        chk("year", 32'h7d0, dt.year);
        chk("month", 32'h1, dt.month);
        chk("day", 32'h1, dt.day);
        wst(3'h1, n);
        chk("field", 32'h1, fld);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk("start dly", 32'ha, r);
        apb(1'b1, 8'h40, 32'h1, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        wr(8'h04, 32'h2);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk("start dly", 32'h2, r);
        wr(8'h08, 32'h1);
        wr(8'h0c, 32'h1);
        wr(8'h10, 32'h3);
    endtask
    task automatic t_manual;
        key <= ESS_KEY_MANUAL_POSITION;
        for (int i = 0; i < 5; i++) begin
            req <= 5'h10 >> i;
            cyc(3);
            chk("field", 32'h5 + i, fld);
            chk("state", 32'h1, st);
        end
        req <= '0;
        cyc(3);
        chk("field", 32'h2, fld);
        key <= ESS_KEY_AUTO;
    endtask
    task automatic t_drop;
        int n;
        req <= 5'h08;
        wst(3'h2, n);
        cyc(2);
        chk("field", 32'h3, fld);
        req <= '0;
        wst(3'h1, n);
        chk("drop", 32'h1, {31'h0, n < 4});
    endtask
    task automatic t_shut;
        int n;
        shut <= 1'b1;
        cyc(1);
        shut <= 1'b0;
        cyc(3);
        chk("latched", 32'h0, st);
        key <= ESS_KEY_OFF;
        cyc(2);
        key <= ESS_KEY_AUTO;
        wst(3'h1, n);
    endtask
    task automatic t_time;
        logic [31:0] r;
        logic e;
        wr(8'h18, 32'h06173b3b);
        cyc(12);
        chk("sec", 32'h1, {31'h0, dt.seconds inside {6'h0, 6'h1}});
        chk("min", 32'h0, dt.minutes);
        chk("hour", 32'h0, dt.hours);
        chk("wday", 32'h0, dt.weekday);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("date", 32'h07d00102, r);
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk("status", 32'h00001011, r);
    endtask
    task automatic t_run(input logic ecu, input logic [7:0] rd,
        input logic abort);
        int n;
        wr(8'h00, {31'h0, ecu});
        run_dly <= rd;
        req <= 5'h10;
        wst(3'h2, n);
        wst(3'h3, n);
        chk("delay", 32'h1, {31'h0, n >= 10 && n <= 22});
        chk("prestart", 32'h1, {31'h0, prestart});
        if (abort) begin
            key <= ESS_KEY_OFF;
            cyc(2);
            chk("prestart", 32'h0, {31'h0, prestart});
        end else begin
            wst(3'h5, n);
            chk("crank", 32'h1, {31'h0, crank});
            chk("warmup", {31'h0, ecu}, {31'h0, saw4});
            wst(3'h6, n);
            chk("handoff", 32'h1, {31'h0, hand});
            chk("crank len", 32'h1,
                {31'h0, rd != 8'h00 ? n < 10 : n >= 20 && n <= 32});
            key <= ESS_KEY_OFF;
            cyc(2);
            chk("crank", 32'h0, {31'h0, crank});
        end
        cyc(3);
        chk("state", 32'h0, st);
        req <= '0;
        run_dly <= 8'h00;
        key <= ESS_KEY_AUTO;
        wst(3'h1, n);
    endtask
    initial begin
        cyc(2);
        reset_i <= 1'b0;
        t_power();
        t_regs();
        t_manual();
        t_drop();
        t_shut();
        t_time();
        t_run(1'b0, 8'h00, 1'b0);
        t_run(1'b1, 8'h04, 1'b0);
        t_run(1'b0, 8'h00, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
